//--- board_straps_model.sv
// Board side: strap resistor on the shared LED pin.
`timescale 1ns/100ps
module board_straps_model (
	// Strap choice and device drive
	input  wire logic strap_val,
	input  wire logic led_out,
	input  wire logic led_oe,
	// Level seen on the pin
	output logic      pin_level
);
	// The resistor wins only while the device does not drive.
	assign pin_level = led_oe ? led_out : strap_val;
endmodule

//--- strap_pkg.sv
// Package: constants and carrier type for the strap sampler and LED driver.
package strap_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int MAX_PORTS = 4;

	// ----------------------------------------------------------------
	// Configuration source select codes
	// ----------------------------------------------------------------
	localparam logic [1:0] CFG_DEFAULT     = 2'h0;
	localparam logic [1:0] CFG_SERIAL_MGMT = 2'h1;
	localparam logic [1:0] CFG_BUS_POWERED = 2'h2;
	localparam logic [1:0] CFG_CONFIG_MEM  = 2'h3;

	// ----------------------------------------------------------------
	// Fixed-port strap decode, one bit per downstream port
	// ----------------------------------------------------------------
	localparam logic [1:0] PAIR_NONE = 2'h0;
	localparam logic [1:0] PAIR_P1   = 2'h1;
	localparam logic [1:0] PAIR_P12  = 2'h2;
	localparam logic [1:0] PAIR_P123 = 2'h3;

	localparam logic [MAX_PORTS-1:0] MASK_NONE = 4'h0;
	localparam logic [MAX_PORTS-1:0] MASK_P1   = 4'h1;
	localparam logic [MAX_PORTS-1:0] MASK_P12  = 4'h3;
	localparam logic [MAX_PORTS-1:0] MASK_P123 = 4'h7;

	// ----------------------------------------------------------------
	// Captured configuration
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0]           cfg_select;
		logic                 straps_enabled;
		logic [1:0]           fixed_port_strap_pair;
		logic [MAX_PORTS-1:0] fixed_port_mask;
		logic                 compound_device;
		logic                 led_active_low;
		logic [MAX_PORTS-1:0] charge_enable;
	} strap_cfg_t;

	localparam strap_cfg_t STRAP_CFG_RESET = '0;

endpackage

//--- strap_sample_led_polarity.sv
// Strap capture at reset release and shared activity LED pin driver.
`timescale 1ns/100ps
module strap_sample_led_polarity #(
	parameter int NUM_PORTS = 4
) (
	// Clock and reset
	input  wire logic                           sys_clk,
	input  wire logic                           reset,
	// Board strap and detect pins
	input  wire logic [1:0]                     cfg_select,
	input  wire logic                           fixed_port_strap_lo,
	input  wire logic                           fixed_port_strap_hi,
	input  wire logic [strap_pkg::MAX_PORTS-1:0] charge_enable_strap,
	input  wire logic                           self_power_detect,
	// Hub state
	input  wire logic                           hub_configured,
	input  wire logic                           hub_suspended,
	// Shared LED pin drive
	output logic                                activity_status_led_out,
	output logic                                activity_status_led_oe,
	// Captured configuration and status
	output strap_pkg::strap_cfg_t               strap_cfg,
	output logic                                config_valid,
	output logic                                self_powered
);

	// ----------------------------------------------------------------
	// Capture
	// ----------------------------------------------------------------
	localparam logic [strap_pkg::MAX_PORTS-1:0] PORT_PRESENT =
		{strap_pkg::MAX_PORTS{1'b1}} >> (strap_pkg::MAX_PORTS - NUM_PORTS);

	strap_pkg::strap_cfg_t cfg_q;
	strap_pkg::strap_cfg_t cfg_d;
	logic                  captured_q;
	logic                  led_out_q;
	logic                  led_oe_q;
	logic                  self_powered_q;

	always_comb begin
		cfg_d = strap_pkg::STRAP_CFG_RESET;
		cfg_d.cfg_select = cfg_select;
		// Serial management and configuration memory setups ignore straps.
		cfg_d.straps_enabled = (cfg_select == strap_pkg::CFG_DEFAULT) ||
			(cfg_select == strap_pkg::CFG_BUS_POWERED);
		if (cfg_d.straps_enabled) begin
			cfg_d.fixed_port_strap_pair =
				{fixed_port_strap_hi, fixed_port_strap_lo};
			cfg_d.charge_enable = charge_enable_strap & PORT_PRESENT;
		end
		unique case (cfg_d.fixed_port_strap_pair)
			strap_pkg::PAIR_NONE: cfg_d.fixed_port_mask = strap_pkg::MASK_NONE;
			strap_pkg::PAIR_P1:   cfg_d.fixed_port_mask = strap_pkg::MASK_P1;
			strap_pkg::PAIR_P12:  cfg_d.fixed_port_mask = strap_pkg::MASK_P12;
			strap_pkg::PAIR_P123: cfg_d.fixed_port_mask = strap_pkg::MASK_P123;
		endcase
		cfg_d.fixed_port_mask = cfg_d.fixed_port_mask & PORT_PRESENT;
		cfg_d.compound_device = |cfg_d.fixed_port_mask;
		// The LED shares the low strap pin, so its own value sets polarity while straps are enabled; otherwise it is active high.
		cfg_d.led_active_low = cfg_d.fixed_port_strap_pair[0];
	end

	// The first edge after release takes the pins; later edges hold them.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			captured_q <= 1'b0;
			cfg_q      <= strap_pkg::STRAP_CFG_RESET;
		end else if (!captured_q) begin
			captured_q <= 1'b1;
			cfg_q      <= cfg_d;
		end
	end

	// ----------------------------------------------------------------
	// Shared LED pin
	// ----------------------------------------------------------------
	// The driver stays off until the strap is safely held, so the board
	// resistor alone sets the pin level while it is being sampled.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			led_oe_q  <= 1'b0;
			led_out_q <= 1'b0;
		end else begin
			led_oe_q  <= captured_q;
			led_out_q <= captured_q &
				((hub_configured & ~hub_suspended) ^
				cfg_q.led_active_low);
		end
	end

	// ----------------------------------------------------------------
	// Self-power detect
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			self_powered_q <= 1'b0;
		end else begin
			self_powered_q <= self_power_detect;
		end
	end

	assign activity_status_led_out = led_out_q;
	assign activity_status_led_oe  = led_oe_q;
	assign strap_cfg               = cfg_q;
	assign config_valid            = captured_q;
	assign self_powered            = self_powered_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	AST_LED_ACTIVE: assert property (
		captured_q && hub_configured && !hub_suspended
		|=> led_out_q == !cfg_q.led_active_low)
		else $error("LED not asserted while hub active");

	AST_LED_IDLE: assert property (
		captured_q && (!hub_configured || hub_suspended)
		|=> led_out_q == cfg_q.led_active_low)
		else $error("LED not negated while hub idle");

	AST_SELF_POWER: assert property (
		self_power_detect |=> self_powered_q)
		else $error("Self power not reported");

	AST_CAPTURE_HELD: assert property (
		captured_q |=> $stable(cfg_q) && captured_q)
		else $error("Captured straps changed");

	AST_DECODE: assert property (
		captured_q |-> cfg_q.fixed_port_mask == (PORT_PRESENT &
		((cfg_q.fixed_port_strap_pair == 2'h0) ? 4'h0 :
		(cfg_q.fixed_port_strap_pair == 2'h1) ? 4'h1 :
		(cfg_q.fixed_port_strap_pair == 2'h2) ? 4'h3 : 4'h7)))
		else $error("Fixed port decode wrong");

	AST_OWN_POLARITY: assert property (
		captured_q |-> cfg_q.led_active_low == cfg_q.fixed_port_strap_pair[0])
		else $error("LED polarity not from own strap");

	AST_CHARGE_READ: assert property (
		!captured_q ##1 captured_q && cfg_q.straps_enabled
		|-> cfg_q.charge_enable == ($past(charge_enable_strap) & PORT_PRESENT))
		else $error("Charge strap not captured");

	AST_STRAPS_GATED: assert property (
		captured_q && !cfg_q.straps_enabled
		|-> cfg_q.charge_enable == 4'h0 && cfg_q.fixed_port_strap_pair == 2'h0)
		else $error("Strap honoured while disabled");

	AST_COMPOUND: assert property (
		captured_q |-> cfg_q.compound_device == (cfg_q.fixed_port_mask != 4'h0))
		else $error("Compound flag wrong");

	AST_SOURCE_SELECT: assert property (
		captured_q |-> cfg_q.straps_enabled == !cfg_q.cfg_select[0])
		else $error("Strap enable not from source select");

	AST_SAMPLE_AT_RELEASE: assert property (
		!captured_q |=> cfg_q.cfg_select == $past(cfg_select))
		else $error("Source select not latched at release");

	AST_DRIVE_AFTER: assert property (
		!captured_q |-> ##1 !led_oe_q ##1 led_oe_q)
		else $error("LED driver enabled at wrong time");

	AST_BUS_POWER: assert property (
		!self_power_detect |=> !self_powered_q)
		else $error("Bus power not reported");

	AST_PAIR_CAPTURE: assert property (
		!captured_q ##1 captured_q && cfg_q.straps_enabled
		|-> cfg_q.fixed_port_strap_pair[1] == $past(fixed_port_strap_hi) &&
		cfg_q.fixed_port_strap_pair[0] == $past(fixed_port_strap_lo))
		else $error("Fixed port pair not captured");

	AST_MASK_PRESENT: assert property (
		captured_q |->
		(cfg_q.fixed_port_mask & ~PORT_PRESENT) == strap_pkg::MASK_NONE &&
		(cfg_q.charge_enable & ~PORT_PRESENT) == strap_pkg::MASK_NONE)
		else $error("Absent port flagged");

	AST_LED_HIGH_ON: assert property (
		captured_q && !cfg_q.fixed_port_strap_pair[0] &&
		hub_configured && !hub_suspended |=> led_out_q)
		else $error("Active high LED not driven high");

	AST_LED_LOW_ON: assert property (
		captured_q && cfg_q.fixed_port_strap_pair[0] &&
		hub_configured && !hub_suspended |=> !led_out_q)
		else $error("Active low LED not driven low");

	AST_FIXED_COMPOUND: assert property (
		captured_q && cfg_q.fixed_port_strap_pair != strap_pkg::PAIR_NONE
		|-> cfg_q.compound_device)
		else $error("Fixed port without compound flag");

	AST_MGMT_NO_STRAPS: assert property (
		captured_q && (cfg_q.cfg_select == strap_pkg::CFG_SERIAL_MGMT ||
		cfg_q.cfg_select == strap_pkg::CFG_CONFIG_MEM)
		|-> !cfg_q.straps_enabled)
		else $error("Straps left on for external setup");

	AST_SELECT_DECIDES: assert property (
		captured_q && (cfg_q.cfg_select == strap_pkg::CFG_DEFAULT ||
		cfg_q.cfg_select == strap_pkg::CFG_BUS_POWERED)
		|-> cfg_q.straps_enabled)
		else $error("Straps off for internal setup");

	AST_LED_QUIET: assert property (
		!captured_q |=> !led_oe_q && !led_out_q)
		else $error("LED driven before capture");

	AST_OE_HELD: assert property (
		led_oe_q |=> led_oe_q)
		else $error("LED driver dropped after capture");

	// ----------------------------------------------------------------
	// Cover points
	// ----------------------------------------------------------------
	COV_LED_ON: cover property (
		led_oe_q && captured_q && hub_configured && !hub_suspended);
	COV_STRAPS_OFF: cover property (captured_q && !cfg_q.straps_enabled);
	COV_COMPOUND_LOW: cover property (
		cfg_q.compound_device && cfg_q.led_active_low);
	COV_SELF_POWERED: cover property (self_powered_q && led_oe_q);
	COV_BUS_CFG: cover property (
		captured_q && cfg_q.cfg_select == strap_pkg::CFG_BUS_POWERED);

endmodule

//--- strap_sample_led_polarity_tb_top.sv
// Testbench for strap capture, LED polarity and self-power report.
`timescale 1ns/100ps
module strap_sample_led_polarity_tb_top;
	logic                  sys_clk, reset, strap_lo, strap_hi, pin;
	logic                  pwr, hub_cfg, hub_susp, led_out, led_oe;
	logic                  cfg_valid, self_pwr, exp_led;
	logic [1:0]            sel;
	logic [3:0]            chg;
	strap_pkg::strap_cfg_t cfg, exp_cfg;
	int                    err_count = 0;
	int                    compares = 0;

	board_straps_model board (.strap_val(strap_lo), .led_out(led_out),
		.led_oe(led_oe), .pin_level(pin));

	strap_sample_led_polarity uut (.sys_clk(sys_clk), .reset(reset),
		.cfg_select(sel), .fixed_port_strap_lo(pin),
		.fixed_port_strap_hi(strap_hi), .charge_enable_strap(chg),
		.self_power_detect(pwr), .hub_configured(hub_cfg),
		.hub_suspended(hub_susp), .activity_status_led_out(led_out),
		.activity_status_led_oe(led_oe), .strap_cfg(cfg),
		.config_valid(cfg_valid), .self_powered(self_pwr));

	task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("Checks %0d, mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	function automatic strap_pkg::strap_cfg_t want(logic [1:0] s,
		logic [1:0] p, logic [3:0] ce);
		strap_pkg::strap_cfg_t e;
		logic                  on;
		on = (s == strap_pkg::CFG_DEFAULT) || (s == strap_pkg::CFG_BUS_POWERED);
		e = strap_pkg::STRAP_CFG_RESET;
		e.cfg_select = s;
		e.straps_enabled = on;
		e.fixed_port_strap_pair = on ? p : 2'h0;
		e.fixed_port_mask = 4'((4'h1 << e.fixed_port_strap_pair) - 4'h1);
		e.compound_device = |e.fixed_port_mask;
		e.led_active_low = e.fixed_port_strap_pair[0];
		e.charge_enable = on ? ce : 4'h0;
		return e;
	endfunction

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// Safety net: a hung run still reaches the verdict.
	initial begin
		#200000;
		err_count++;
		test_done();
	end

	initial begin
		reset = 1'b1;
		sel = 2'h0;
		strap_lo = 1'b0;
		strap_hi = 1'b0;
		chg = 4'h0;
		pwr = 1'b0;
		hub_cfg = 1'b0;
		hub_susp = 1'b0;
		for (int c = 0; c < 16; c++) begin
			@(posedge sys_clk);
			reset <= 1'b1;
			sel <= c[3:2];
			strap_hi <= c[1];
			strap_lo <= c[0];
			chg <= 4'hA ^ c[3:0];
			hub_cfg <= 1'b1;
			repeat (2) @(posedge sys_clk);
			#1 chk("oe_in_reset", 16'(led_oe), 16'h0);
			chk("led_in_reset", 16'(led_out), 16'h0);
			chk("valid_in_reset", 16'(cfg_valid), 16'h0);
			chk("cfg_in_reset", 16'(cfg), 16'h0);
			@(posedge sys_clk);
			reset <= 1'b0;
			@(posedge sys_clk);
			// Late pin changes must not reach the captured set.
			strap_hi <= ~c[1];
			strap_lo <= ~c[0];
			chg <= ~chg;
			#1 exp_cfg = want(c[3:2], c[1:0], 4'hA ^ c[3:0]);
			chk("cfg", 16'(cfg), 16'(exp_cfg));
			chk("valid", 16'(cfg_valid), 16'h1);
			chk("oe_at_capture", 16'(led_oe), 16'h0);
			@(posedge sys_clk);
			#1 chk("oe_after", 16'(led_oe), 16'h1);
			chk("cfg_held", 16'(cfg), 16'(exp_cfg));
			for (int h = 0; h < 4; h++) begin
				@(posedge sys_clk);
				hub_cfg <= h[1];
				hub_susp <= h[0];
				pwr <= h[0];
				@(posedge sys_clk);
				#1 exp_led = (h == 2) ^ exp_cfg.led_active_low;
				chk("led", 16'(led_out), 16'(exp_led));
				chk("oe_held", 16'(led_oe), 16'h1);
				chk("self_pwr", 16'(self_pwr), 16'(h[0]));
			end
			$display("Case %0d done", c);
		end
		test_done();
	end
endmodule
